/* rtl/hadc_params.svh */
// constants for the haptic actuator drive configuration block
// What this block does
// (R1) after reset, wait the 1.5 ms boot interval, then enter inactive lowest-power mode
// (R2) actuator kind bit: 0 selects resonant actuator, 1 selects rotating mass
// (R3) nominal voltage code, 8 bits at 23.4 mV per step, sets steady full scale
// (R4) peak voltage code, 8 bits at 23.4 mV per step, absolute drive ceiling
// (R5) host programs current limit code as (rated mA minus 28.6) over 7.2
// (R6) impedance factor is high byte concatenated with low byte, sixteen bits
// (R7) resonance period is high times 128 plus low, 1333.32 ns per count
// (R8) rotating mass uses the resonance period as back-emf sensing interval
// (R9) overdrive and fast-brake act only while frequency tracking is enabled
// (R10) overdrive and fast-brake each act only while their own enable is set
// (R11) overdrive boosts or cuts drive whenever a nonzero magnitude differs from the last one received, no calibration
// (R12) amplitude is unsigned with overdrive off, signed with overdrive on
// (R13) fast-brake drives full reverse: phase flip or inverted voltage
// (R14) wideband allowed in override and playback modes, 25 to 1000 Hz
// (R15) in wideband override mode, new period writes change the drive frequency
// (R16) sequence author puts frequency in first frame when start frequency matters
// (R17) host loads memory only when inactive, idle and 1.5 ms after boot
// (R18) memory write allow bit: 1 permits writes, 0 blocks them
// (R19) device reports base location of the first memory word for host writes
// (R20) memory empty after power-up, retained until reset, rewritable freely
// (R21) transitions may reach peak level or reverse; steady state uses nominal
`ifndef HADC_PARAMS_SVH
`define HADC_PARAMS_SVH
`define HADC_CLK_HZ 20000000
`define HADC_BOOT_NS 1500000
`define HADC_BOOT_CYC ((`HADC_BOOT_NS * (`HADC_CLK_HZ / 1000000) + 999) / 1000)
`define HADC_PER_LO_W 7
`define HADC_KIND_LRA 1'h0
`define HADC_KIND_ERM 1'h1
`define HADC_BASE_LOC 16'h0084
`define HADC_MEM_DEPTH 128
`define HADC_MEM_AW 7
`endif

/* rtl/hadc_pkg.sv */
// types for the haptic actuator drive configuration block
package hadc_pkg;
  typedef enum logic [2:0] {
    HADC_INACTIVE,
    HADC_OVERRIDE,
    HADC_PWM,
    HADC_REG_TRIG,
    HADC_EDGE_TRIG
  } hadc_mode_t;
  typedef enum {ST_BOOT, ST_INACTIVE, ST_ACTIVE} hadc_state_t;
endpackage

/* rtl/hadc_cfg.sv */
// haptic actuator drive configuration and drive-level control
`timescale 1ns/1ps
`include "hadc_params.svh"
module hadc_cfg #(
  parameter int BOOT_CYC = `HADC_BOOT_CYC,
  parameter int MEM_DEPTH = `HADC_MEM_DEPTH,
  parameter int MEM_AW = `HADC_MEM_AW
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // actuator setup
  input wire logic actuator_kind,
  input wire logic [7:0] nominal_code,
  input wire logic [7:0] peak_code,
  input wire logic [4:0] current_limit_code,
  input wire logic [7:0] impedance_factor_hi,
  input wire logic [7:0] impedance_factor_lo,
  input wire logic [7:0] resonance_period_hi,
  input wire logic [6:0] resonance_period_lo,
  input wire logic period_wr,
  // feature enables and mode
  input wire logic freq_track_en,
  input wire logic overdrive_en,
  input wire logic fast_brake_en,
  input wire logic [2:0] mode_sel,
  input wire logic playback_busy,
  // amplitude input
  input wire logic amp_valid,
  input wire logic [7:0] amp_in,
  // waveform memory port
  input wire logic wavemem_write_allow,
  input wire logic mem_wr,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic [15:0] wavemem_base_loc,
  output logic mem_wr_refused,
  // status and drive outputs
  output logic boot_done,
  output logic inactive,
  output logic [15:0] impedance_factor,
  output logic [14:0] resonance_period,
  output logic [14:0] sense_interval,
  output logic period_changed,
  output logic overdrive_act,
  output logic brake_act,
  output logic drive_reverse,
  output logic [7:0] drive_level,
  output logic [7:0] level_limit
);
  // ****************
  // state and working signals
  // ****************
  typedef struct packed {
    hadc_pkg::hadc_state_t st;
    logic [31:0] cnt;
    logic [7:0] prev_amp;
    logic [7:0] level;
    logic [7:0] limit;
    logic od;
    logic brk;
    logic rev;
    logic [15:0] imp;
    logic [14:0] per;
    logic [14:0] sense;
    logic pchg;
    logic [7:0] rdata;
    logic refused;
  } hadc_st_t;
  hadc_st_t s_r, s_nxt;
  logic [7:0] mem_r [MEM_DEPTH];
  logic mem_we;
  logic od_ok, brk_ok, wide;
  logic [7:0] mag;
  logic neg;
  genvar gi;

  // ****************
  // mode decoding
  // ****************
  // idle request: drive stops and the memory port opens again
  function automatic logic is_idle_mode(input logic [2:0] m);
    return m == 3'(hadc_pkg::HADC_INACTIVE);
  endfunction
  // (R14) modes that accept wideband drive; pwm streaming does not
  function automatic logic is_wide_mode(input logic [2:0] m);
    return m == 3'(hadc_pkg::HADC_OVERRIDE) || m == 3'(hadc_pkg::HADC_REG_TRIG)
      || m == 3'(hadc_pkg::HADC_EDGE_TRIG);
  endfunction

  // ****************
  // feature gating
  // ****************
  // (R9) (R10) feature gating by tracking and own enable
  assign od_ok = overdrive_en && freq_track_en;
  assign brk_ok = fast_brake_en && freq_track_en;
  // wideband needs tracking off, as the loop would fight new period writes
  assign wide = !freq_track_en && is_wide_mode(mode_sel);
  // (R12) signed amplitude only with overdrive on
  assign neg = overdrive_en && amp_in[7];
  // 0x80 negates to itself and reads as full-scale reverse
  assign mag = neg ? 8'(-amp_in) : amp_in;
  // (R17) (R18) writes only when allowed, booted and idle
  assign mem_we = mem_wr && wavemem_write_allow && s_r.st == hadc_pkg::ST_INACTIVE
    && !playback_busy;

  // ****************
  // next state
  // ****************
  always_comb begin
    s_nxt = s_r;
    s_nxt.pchg = 1'h0;
    // a refused write leaves memory untouched and flags for one cycle
    s_nxt.refused = mem_wr && !mem_we;
    // read data lags the address by one cycle
    s_nxt.rdata = mem_r[mem_addr];
    // (R6) concatenated impedance factor
    s_nxt.imp = {impedance_factor_hi, impedance_factor_lo};
    // (R7) period high times 128 plus low
    s_nxt.per = {resonance_period_hi, resonance_period_lo};
    // (R2) (R8) kind bit picks rotating-mass sensing
    s_nxt.sense = (actuator_kind == `HADC_KIND_ERM) ? s_nxt.per : 15'h0000;
    // (R15) (R14) wideband override period write changes frequency
    if (period_wr && wide && s_r.st == hadc_pkg::ST_ACTIVE) begin
      s_nxt.pchg = 1'h1;
    end
    case (s_r.st)
      // (R1) boot interval then inactive
      hadc_pkg::ST_BOOT: begin
        if (s_r.cnt >= 32'(BOOT_CYC - 1)) begin
          s_nxt.st = hadc_pkg::ST_INACTIVE;
          s_nxt.cnt = 32'h0;
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h1;
        end
      end
      hadc_pkg::ST_INACTIVE: begin
        // lowest power: drive and transition flags forced off
        s_nxt.level = 8'h00;
        s_nxt.od = 1'h0;
        s_nxt.brk = 1'h0;
        s_nxt.rev = 1'h0;
        if (!is_idle_mode(mode_sel)) begin
          s_nxt.st = hadc_pkg::ST_ACTIVE;
        end
      end
      hadc_pkg::ST_ACTIVE: begin
        if (is_idle_mode(mode_sel)) begin
          s_nxt.st = hadc_pkg::ST_INACTIVE;
        end else if (amp_valid) begin
          s_nxt.prev_amp = mag;
          s_nxt.level = mag;
          s_nxt.rev = neg;
          // (R11) (R21) overdrive on level change lifts ceiling to peak
          s_nxt.od = od_ok && mag != s_r.prev_amp && mag != 8'h00;
          // (R13) fast-brake reverses drive when stopping
          s_nxt.brk = brk_ok && mag == 8'h00 && s_r.prev_amp != 8'h00;
          if (s_nxt.brk) begin
            s_nxt.rev = 1'h1;
          end
        end else begin
          // (R21) settle back to nominal after one transition cycle
          s_nxt.od = 1'h0;
          s_nxt.brk = 1'h0;
          if (s_r.brk) begin
            s_nxt.rev = 1'h0;
          end
        end
      end
      default: s_nxt.st = hadc_pkg::ST_BOOT;
    endcase
    // (R3) (R4) limit: peak in transitions, nominal in steady state
    s_nxt.limit = (s_nxt.od || s_nxt.brk) ? peak_code : nominal_code;
  end

  // ****************
  // state register
  // ****************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************
  // waveform memory
  // ****************
  // (R20) memory cleared at power-on reset, rewritable any number of times
  generate
    for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_word
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          mem_r[gi] <= 8'h00;
        end else if (mem_we && mem_addr == MEM_AW'(gi)) begin
          mem_r[gi] <= mem_wdata;
        end
      end
    end
  endgenerate

  // ****************
  // base location
  // ****************
  // (R19) reported base location of first snippet word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wavemem_base_loc <= `HADC_BASE_LOC;
    end else begin
      wavemem_base_loc <= `HADC_BASE_LOC;
    end
  end

  // ****************
  // outputs, all from flops
  // ****************
  assign mem_rdata = s_r.rdata;
  assign mem_wr_refused = s_r.refused;
  assign boot_done = s_r.st != hadc_pkg::ST_BOOT;
  assign inactive = s_r.st == hadc_pkg::ST_INACTIVE;
  assign impedance_factor = s_r.imp;
  assign resonance_period = s_r.per;
  assign sense_interval = s_r.sense;
  assign period_changed = s_r.pchg;
  assign overdrive_act = s_r.od;
  assign brake_act = s_r.brk;
  assign drive_reverse = s_r.rev;
  assign drive_level = s_r.level;
  assign level_limit = s_r.limit;

  // ****************
  // assertions
  // ****************
  a_boot_length: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    $rose(boot_done) |-> $past(s_r.cnt) == 32'(BOOT_CYC - 1))
    else $error("boot interval wrong");
  a_od_gate: assert property (@(posedge ref_clk) disable iff (rst) // (R9)
    overdrive_act |-> $past(freq_track_en) && $past(overdrive_en))
    else $error("overdrive without enables");
  a_brk_gate: assert property (@(posedge ref_clk) disable iff (rst) // (R10)
    brake_act |-> $past(freq_track_en) && $past(fast_brake_en))
    else $error("brake without enables");
  a_brk_rev: assert property (@(posedge ref_clk) disable iff (rst) // (R13)
    brake_act |-> drive_reverse && drive_level == 8'h00)
    else $error("brake not reversed");
  a_imp_cat: assert property (@(posedge ref_clk) disable iff (rst) // (R6)
    ##1 impedance_factor == {$past(impedance_factor_hi), $past(impedance_factor_lo)})
    else $error("impedance factor wrong");
  a_per_cat: assert property (@(posedge ref_clk) disable iff (rst) // (R7)
    ##1 resonance_period == 15'($past(resonance_period_hi) * 128 + $past(resonance_period_lo)))
    else $error("period wrong");
  a_limit_sel: assert property (@(posedge ref_clk) disable iff (rst) // (R21)
    boot_done && !overdrive_act && !brake_act |-> level_limit == $past(nominal_code))
    else $error("steady limit not nominal");
  a_mem_block: assert property (@(posedge ref_clk) disable iff (rst) // (R18)
    mem_wr && !wavemem_write_allow |=> mem_wr_refused)
    else $error("blocked write not refused");
  a_erm_sense: assert property (@(posedge ref_clk) disable iff (rst) // (R8)
    actuator_kind |=> sense_interval == {$past(resonance_period_hi), $past(resonance_period_lo)})
    else $error("sense interval wrong");
  a_boot_idle: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    $rose(boot_done) |-> inactive && drive_level == 8'h00)
    else $error("boot did not end in inactive mode");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    inactive && $past(inactive) |-> drive_level == 8'h00 && !drive_reverse)
    else $error("drive while inactive");
  a_lra_sense: assert property (@(posedge ref_clk) disable iff (rst) // (R2)
    !actuator_kind |=> sense_interval == 15'h0000)
    else $error("resonant actuator given a sense interval");
  a_trans_peak: assert property (@(posedge ref_clk) disable iff (rst) // (R4)
    overdrive_act || brake_act |-> level_limit == $past(peak_code))
    else $error("transition limit not peak");
  a_od_change: assert property (@(posedge ref_clk) disable iff (rst) // (R11)
    overdrive_act |-> $past(amp_valid) && drive_level != 8'h00)
    else $error("overdrive without a level change");
  a_amp_unsigned: assert property (@(posedge ref_clk) disable iff (rst) // (R12)
    amp_valid && !overdrive_en && amp_in != 8'h00 && s_r.st == hadc_pkg::ST_ACTIVE
    && !is_idle_mode(mode_sel) |=> drive_level == $past(amp_in) && !drive_reverse)
    else $error("unsigned amplitude misread");
  a_amp_signed: assert property (@(posedge ref_clk) disable iff (rst) // (R12)
    amp_valid && overdrive_en && amp_in[7] && s_r.st == hadc_pkg::ST_ACTIVE
    && !is_idle_mode(mode_sel) |=> drive_reverse && drive_level == 8'(-$past(amp_in)))
    else $error("signed amplitude misread");
  a_brk_on_stop: assert property (@(posedge ref_clk) disable iff (rst) // (R13)
    brake_act |-> $past(amp_valid) && $past(amp_in) == 8'h00)
    else $error("brake without a stop");
  a_brk_release: assert property (@(posedge ref_clk) disable iff (rst) // (R21)
    brake_act && !amp_valid && !is_idle_mode(mode_sel) |=> !drive_reverse)
    else $error("reverse held after brake");
  a_wide_period: assert property (@(posedge ref_clk) disable iff (rst) // (R14)
    period_changed |-> $past(period_wr) && !$past(freq_track_en))
    else $error("frequency change outside wideband");
  a_wide_freq: assert property (@(posedge ref_clk) disable iff (rst) // (R15)
    period_wr && !freq_track_en && is_wide_mode(mode_sel)
    && s_r.st == hadc_pkg::ST_ACTIVE |=> period_changed)
    else $error("period write did not change frequency");
  a_mem_idle: assert property (@(posedge ref_clk) disable iff (rst) // (R17)
    mem_wr && (!inactive || playback_busy) |=> mem_wr_refused)
    else $error("write taken while not idle");
  a_mem_store: assert property (@(posedge ref_clk) disable iff (rst) // (R20)
    mem_we |=> mem_r[$past(mem_addr)] == $past(mem_wdata))
    else $error("memory word not stored");
endmodule // hadc_cfg

/* sim/hadc_host.sv */
// host model that programs the setup codes and loads the waveform memory
`timescale 1ns/1ps
module hadc_host (
  // clock and status
  input wire logic ref_clk,
  input wire logic inactive,
  input wire logic [15:0] wavemem_base_loc,
  // setup codes
  output logic [4:0] current_limit_code,
  output logic [7:0] impedance_factor_hi,
  output logic [7:0] impedance_factor_lo,
  output logic [7:0] resonance_period_hi,
  output logic [6:0] resonance_period_lo,
  output logic period_wr,
  // memory port
  output logic wavemem_write_allow,
  output logic mem_wr,
  output logic [6:0] mem_addr,
  output logic [7:0] mem_wdata
);
  // ****************************************
  // host procedures
  // ****************************************
  initial {current_limit_code, impedance_factor_hi, impedance_factor_lo, resonance_period_hi,
    resonance_period_lo, period_wr, wavemem_write_allow, mem_wr, mem_addr, mem_wdata} = '0;
  task automatic period(input real hz);
    int p;
    p = $rtoi(1.0 / (hz * 1333.32e-9));
    @(negedge ref_clk);
    {resonance_period_hi, resonance_period_lo} = p[14:0];
    period_wr = 1'b1;
    @(negedge ref_clk);
    period_wr = 1'b0;
  endtask
  // codes from ratings; truncation keeps the current below the rating
  task automatic setup(input real ma, input real ohm, input real hz);
    int c;
    int z;
    c = $rtoi((ma - 28.6) / 7.2);
    z = $rtoi(ohm * (c + 4) / 1.6104);
    @(negedge ref_clk);
    current_limit_code = c[4:0];
    {impedance_factor_hi, impedance_factor_lo} = z[15:0];
    period(hz);
  endtask
  // allow bit set with the word; released data shows its inverse
  task automatic wr(input logic allow, input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    wavemem_write_allow = allow;
    {mem_addr, mem_wdata, mem_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    {mem_wdata, mem_wr} = {~d, 1'b0};
  endtask
  // upload once inactive, at the base
  task automatic load(input logic [7:0] d);
    wait (inactive === 1'b1);
    wr(1'b1, wavemem_base_loc[6:0], d);
  endtask
endmodule // hadc_host

/* sim/hadc_cfg_bench.sv */
// self-checking bench for the drive configuration block
`timescale 1ns/1ps
module hadc_cfg_bench;
  logic ref_clk, rst, actuator_kind, period_wr, freq_track_en, overdrive_en, fast_brake_en;
  logic playback_busy, amp_valid, wavemem_write_allow, mem_wr, mem_wr_refused, boot_done;
  logic inactive, period_changed, overdrive_act, brake_act, drive_reverse;
  logic [2:0] mode_sel;
  logic [4:0] current_limit_code;
  logic [6:0] resonance_period_lo, mem_addr;
  logic [7:0] nominal_code, peak_code, impedance_factor_hi, impedance_factor_lo, amp_in;
  logic [7:0] resonance_period_hi, mem_wdata, mem_rdata, drive_level, level_limit;
  logic [14:0] resonance_period, sense_interval;
  logic [15:0] wavemem_base_loc, impedance_factor;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  // ****************************************
  // harness
  // ****************************************
  hadc_cfg #(.BOOT_CYC(20)) dut (.ref_clk, .rst, .actuator_kind, .nominal_code, .peak_code,
    .current_limit_code, .impedance_factor_hi, .impedance_factor_lo, .resonance_period_hi,
    .resonance_period_lo, .period_wr, .freq_track_en, .overdrive_en, .fast_brake_en, .mode_sel,
    .playback_busy, .amp_valid, .amp_in, .wavemem_write_allow, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .wavemem_base_loc, .mem_wr_refused, .boot_done, .inactive, .impedance_factor,
    .resonance_period, .sense_interval, .period_changed, .overdrive_act, .brake_act,
    .drive_reverse, .drive_level, .level_limit);
  hadc_host host (.ref_clk, .inactive, .wavemem_base_loc, .current_limit_code,
    .impedance_factor_hi, .impedance_factor_lo, .resonance_period_hi, .resonance_period_lo,
    .period_wr, .wavemem_write_allow, .mem_wr, .mem_addr, .mem_wdata);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // a hang costs one mismatch and ends the run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic amp(input logic [7:0] v);
    @(negedge ref_clk);
    {amp_in, amp_valid} = {v, 1'b1};
    @(negedge ref_clk);
    {amp_in, amp_valid} = {~v, 1'b0};
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {actuator_kind, freq_track_en, overdrive_en, fast_brake_en, playback_busy, amp_valid} = '0;
    {mode_sel, nominal_code, peak_code, amp_in} = '0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    chk(wavemem_base_loc, 16'h0084);
    host.wr(1'b1, 7'h04, 8'h5a);
    chk(mem_wr_refused, 1'h1);
    chk(boot_done, 1'h0);
    @(negedge ref_clk);
    chk(mem_rdata, 8'h00);
    repeat (22) @(negedge ref_clk);
    chk({boot_done, inactive}, 2'h3);
    host.wr(1'b0, 7'h04, 8'h3c);
    chk(mem_wr_refused, 1'h1);
    host.load(8'h3c);
    chk(mem_wr_refused, 1'h0);
    @(negedge ref_clk);
    chk(mem_rdata, 8'h3c);
    host.load(8'hc3);
    @(negedge ref_clk);
    chk(mem_rdata, 8'hc3);
    host.setup(100.0, 32.0, 170.0);
    @(negedge ref_clk);
    chk(impedance_factor, 16'h0102);
    chk(resonance_period, 15'h113b);
    chk(sense_interval, 15'h0000);
    actuator_kind = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(sense_interval, 15'h113b);
    {actuator_kind, freq_track_en, overdrive_en, fast_brake_en} = 4'h7;
    {nominal_code, peak_code, mode_sel} = {8'h50, 8'h90, 3'h1};
    repeat (2) @(negedge ref_clk);
    host.wr(1'b1, 7'h04, 8'h11);
    chk(mem_wr_refused, 1'h1);
    amp(8'h40);
    chk({drive_level, overdrive_act}, {8'h40, 1'h1});
    chk(level_limit, 8'h90);
    @(negedge ref_clk);
    chk({level_limit, overdrive_act}, {8'h50, 1'h0});
    amp(8'h00);
    chk({brake_act, drive_reverse}, 2'h3);
    amp(8'hc0);
    chk({drive_level, drive_reverse}, {8'h40, 1'h1});
    freq_track_en = 1'b0;
    amp(8'h20);
    chk(overdrive_act, 1'h0);
    amp(8'h00);
    chk(brake_act, 1'h0);
    {freq_track_en, overdrive_en} = 2'h2;
    amp(8'hc0);
    chk({drive_level, drive_reverse, overdrive_act}, {8'hc0, 2'h0});
    fast_brake_en = 1'b0;
    amp(8'h00);
    chk(brake_act, 1'h0);
    freq_track_en = 1'b0;
    for (int m = 1; m < 5; m++) begin
      mode_sel = m[2:0];
      repeat (2) @(negedge ref_clk);
      host.period(250.0);
      chk(period_changed, {15'h0, m != 2});
    end
    @(negedge ref_clk);
    chk(resonance_period, 15'h0bb8);
    give_verdict;
  end
endmodule // hadc_cfg_bench
